// file: rtl/orx_params.svh
// Constants for the OR, return and rotate execution block
`ifndef ORX_PARAMS_SVH
`define ORX_PARAMS_SVH
`define ORX_DATA_W 8
`define ORX_ADDR_W 4
`define ORX_PC_W 11
`define ORX_STACK_DEPTH 8
`define ORX_SP_W 3
`define ORX_CYC_ALU 1
`define ORX_CYC_EXIT 2
`define ORX_WORK_RST 8'h00
`define ORX_FLAG_Z 0
`define ORX_FLAG_C 1
`endif

// file: rtl/orx_pkg.sv
// Types for the OR, return and rotate execution block
package orx_pkg;
    typedef enum logic [2:0]
    {
        ORX_OP_NONE = 3'b000,
        ORX_OP_ORI = 3'b001,
        ORX_OP_ORW = 3'b010,
        ORX_OP_OR_INTO = 3'b011,
        ORX_OP_SUB_EXIT = 3'b100,
        ORX_OP_LIT_EXIT = 3'b101,
        ORX_OP_IRQ_EXIT = 3'b110,
        ORX_OP_ROT_LEFT = 3'b111
    } orx_op_t;

    typedef struct packed
    {
        orx_op_t op;
        logic [3:0] addr;
        logic [7:0] literal;
    } orx_instr_t;

    typedef struct packed
    {
        logic [10:0] pc;
        logic is_irq;
    } orx_call_t;

    typedef enum logic [0:0]
    {
        ORX_ST_EXEC = 1'b0,
        ORX_ST_EXIT2 = 1'b1
    } orx_state_t;
endpackage

// file: rtl/orx_exec.sv
// Execution core for OR, subroutine/interrupt return and rotate-left-through-carry
// What this block does
// - OR literal with working register into working register, one cycle, zero flag only.
// - OR data register with working register into working register, one cycle, zero flag only.
// - OR data register with working register back into data register, one cycle, zero flag.
// - Subroutine exit takes two cycles, flags kept, resumes after the call.
// - Exit with literal takes two cycles, loads literal into working register, flags kept.
// - Rotate register left through carry flag into working register, one cycle.
`timescale 1ns/1ps
`include "orx_params.svh"
module orx_exec
    import orx_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Instruction issue
    input wire logic instr_valid,
    input wire orx_instr_t instr,
    // Call entry from the rest of the core
    input wire logic call_push,
    input wire orx_call_t call_frame,
    // Results
    output logic instr_ready,
    output logic [7:0] working_register,
    output logic result_null_flag,
    output logic rotate_bit_flag,
    output logic [10:0] pc_out,
    output logic pc_load,
    output logic irq_return,
    output logic [7:0] data_reg_view [16]
);
    logic [7:0] data_reg [16];
    logic [7:0] work_reg, work_next;
    logic z_reg, z_next, c_reg, c_next;
    orx_call_t stack_reg [`ORX_STACK_DEPTH];
    logic [`ORX_SP_W-1:0] sp_reg;
    orx_state_t state_reg;
    logic [7:0] lit_reg;
    orx_op_t op_reg;
    logic pc_load_reg, irq_exit_reg, ready_reg;
    logic [10:0] pc_reg;

    // Operation class decoders
    function automatic logic is_or_op(input orx_op_t op);
        return op == ORX_OP_ORI || op == ORX_OP_ORW || op == ORX_OP_OR_INTO;
    endfunction

    function automatic logic is_exit_op(input orx_op_t op);
        return op == ORX_OP_SUB_EXIT || op == ORX_OP_LIT_EXIT || op == ORX_OP_IRQ_EXIT;
    endfunction

    wire take = instr_valid && state_reg == ORX_ST_EXEC;
    wire [7:0] reg_val = data_reg[instr.addr];
    wire [7:0] or_src = (instr.op == ORX_OP_ORI) ? instr.literal : reg_val;
    wire [7:0] or_res = work_reg | or_src;
    wire [7:0] rot_res = {reg_val[6:0], c_reg};
    wire is_or = is_or_op(instr.op);
    wire is_exit = is_exit_op(instr.op);
    wire lit_load = state_reg == ORX_ST_EXIT2 && op_reg == ORX_OP_LIT_EXIT;
    wire [`ORX_SP_W-1:0] sp_top = sp_reg - 3'h1;

    always_comb
    begin
        work_next = work_reg;
        z_next = z_reg;
        c_next = c_reg;
        if (take && is_or)
        begin
            z_next = (or_res == 8'h00);
            if (instr.op != ORX_OP_OR_INTO)
                work_next = or_res;
        end
        if (take && instr.op == ORX_OP_ROT_LEFT)
        begin
            work_next = rot_res;
            c_next = reg_val[7];
        end
        if (lit_load)
            work_next = lit_reg;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            work_reg <= `ORX_WORK_RST;
            z_reg <= 1'b0;
            c_reg <= 1'b0;
        end
        else
        begin
            work_reg <= work_next;
            z_reg <= z_next;
            c_reg <= c_next;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_dreg
            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                    data_reg[gi] <= 8'h00;
                else if (take && instr.op == ORX_OP_OR_INTO && instr.addr == 4'(gi))
                    data_reg[gi] <= or_res;
            end
            assign data_reg_view[gi] = data_reg[gi];
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_reg <= ORX_ST_EXEC;
            sp_reg <= 3'h0;
            op_reg <= ORX_OP_NONE;
            lit_reg <= 8'h00;
            pc_reg <= 11'h000;
            pc_load_reg <= 1'b0;
            irq_exit_reg <= 1'b0;
            ready_reg <= 1'b1;
        end
        else
        begin
            pc_load_reg <= 1'b0;
            irq_exit_reg <= 1'b0;
            unique case (state_reg)
                ORX_ST_EXIT2:
                begin
                    state_reg <= ORX_ST_EXEC;
                    ready_reg <= 1'b1;
                    pc_load_reg <= 1'b1;
                    irq_exit_reg <= op_reg == ORX_OP_IRQ_EXIT;
                end
                ORX_ST_EXEC:
                begin
                    if (take && is_exit)
                    begin
                        state_reg <= ORX_ST_EXIT2;
                        ready_reg <= 1'b0;
                        op_reg <= instr.op;
                        lit_reg <= instr.literal;
                        pc_reg <= stack_reg[sp_top].pc;
                        sp_reg <= sp_top;
                    end
                    else if (call_push)
                    begin
                        stack_reg[sp_reg] <= call_frame;
                        sp_reg <= sp_reg + 3'h1;
                    end
                end
            endcase
        end
    end

    assign working_register = work_reg;
    assign result_null_flag = z_reg;
    assign rotate_bit_flag = c_reg;
    assign pc_out = pc_reg;
    assign pc_load = pc_load_reg;
    assign irq_return = irq_exit_reg;
    assign instr_ready = ready_reg;

    property p_or_flag;
        @(posedge clk_sys) disable iff (sys_rst)
        take && is_or |=> result_null_flag == ($past(or_res) == 8'h00);
    endproperty
    a_or_flag: assert property (p_or_flag) else $error("OR zero flag wrong");

    property p_or_work;
        @(posedge clk_sys) disable iff (sys_rst)
        take && (instr.op == ORX_OP_ORW || instr.op == ORX_OP_ORI) |=> working_register == $past(or_res);
    endproperty
    a_or_work: assert property (p_or_work) else $error("OR result not in working register");

    property p_or_into_keep;
        @(posedge clk_sys) disable iff (sys_rst)
        take && instr.op == ORX_OP_OR_INTO |=> working_register == $past(work_reg);
    endproperty
    a_or_into_keep: assert property (p_or_into_keep) else $error("OR into register changed working register");

    property p_or_into_reg;
        @(posedge clk_sys) disable iff (sys_rst)
        take && instr.op == ORX_OP_OR_INTO |=> data_reg_view[$past(instr.addr)] == $past(or_res);
    endproperty
    a_or_into_reg: assert property (p_or_into_reg) else $error("OR result not in data register");

    property p_exit_two;
        @(posedge clk_sys) disable iff (sys_rst)
        take && is_exit |=> !instr_ready ##1 (instr_ready && pc_load);
    endproperty
    a_exit_two: assert property (p_exit_two) else $error("Return not two cycles");

    property p_lit_exit_work;
        @(posedge clk_sys) disable iff (sys_rst)
        take && instr.op == ORX_OP_LIT_EXIT |=> ##1 working_register == $past(instr.literal, 2);
    endproperty
    a_lit_exit_work: assert property (p_lit_exit_work) else $error("Return literal not loaded");

    property p_exit_flags;
        @(posedge clk_sys) disable iff (sys_rst)
        take && is_exit |=> $stable(result_null_flag) && $stable(rotate_bit_flag);
    endproperty
    a_exit_flags: assert property (p_exit_flags) else $error("Return changed flags");

    property p_rot;
        @(posedge clk_sys) disable iff (sys_rst)
        take && instr.op == ORX_OP_ROT_LEFT |=> working_register == $past(rot_res) && rotate_bit_flag == $past(reg_val[7]);
    endproperty
    a_rot: assert property (p_rot) else $error("Rotate result wrong");

    property p_irq_exit;
        @(posedge clk_sys) disable iff (sys_rst)
        take && instr.op == ORX_OP_IRQ_EXIT |=> ##1 irq_return && pc_out == $past(stack_reg[sp_top].pc, 2);
    endproperty
    a_irq_exit: assert property (p_irq_exit) else $error("Interrupt return pc wrong");

    // Main scenarios
    c_or_into: cover property (@(posedge clk_sys) take && instr.op == ORX_OP_OR_INTO);
    c_lit_exit: cover property (@(posedge clk_sys) take && instr.op == ORX_OP_LIT_EXIT);
    c_irq_exit: cover property (@(posedge clk_sys) irq_return);
    c_rot: cover property (@(posedge clk_sys) take && instr.op == ORX_OP_ROT_LEFT && c_reg);
endmodule

// file: bench/or_return_rotate_exec_test.sv
// Self-checking bench for the OR, return and rotate execution block
`timescale 1ns/1ps
module or_return_rotate_exec_test
    import orx_pkg::*;
;
    typedef struct packed
    {
        orx_op_t op;
        logic [3:0] addr;
        logic [7:0] lit;
        logic [7:0] work;
        logic z;
        logic c;
        logic [7:0] rv;
    } orx_row_t;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic instr_valid = 1'b0;
    orx_instr_t instr = '0;
    logic call_push = 1'b0;
    orx_call_t call_frame = '0;
    logic instr_ready, result_null_flag, rotate_bit_flag, pc_load, irq_return;
    logic [7:0] working_register;
    logic [10:0] pc_out;
    logic [7:0] view [16];
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    orx_row_t rows [13] = '{
        '{ORX_OP_ORI, 4'h0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
        '{ORX_OP_ORI, 4'h0, 8'h0A, 8'h0A, 1'b0, 1'b0, 8'h00},
        '{ORX_OP_OR_INTO, 4'h1, 8'h00, 8'h0A, 1'b0, 1'b0, 8'h0A},
        '{ORX_OP_LIT_EXIT, 4'h0, 8'h30, 8'h30, 1'b0, 1'b0, 8'h00},
        '{ORX_OP_ORW, 4'h1, 8'h00, 8'h3A, 1'b0, 1'b0, 8'h0A},
        '{ORX_OP_OR_INTO, 4'h2, 8'h00, 8'h3A, 1'b0, 1'b0, 8'h3A},
        '{ORX_OP_LIT_EXIT, 4'h0, 8'h81, 8'h81, 1'b0, 1'b0, 8'h00},
        '{ORX_OP_OR_INTO, 4'h3, 8'h00, 8'h81, 1'b0, 1'b0, 8'h81},
        '{ORX_OP_ROT_LEFT, 4'h3, 8'h00, 8'h02, 1'b0, 1'b1, 8'h81},
        '{ORX_OP_ROT_LEFT, 4'h3, 8'h00, 8'h03, 1'b0, 1'b1, 8'h81},
        '{ORX_OP_ROT_LEFT, 4'h2, 8'h00, 8'h75, 1'b0, 1'b0, 8'h3A},
        '{ORX_OP_LIT_EXIT, 4'h0, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00},
        '{ORX_OP_ORW, 4'h0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00}
    };
    orx_exec dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
        .call_push(call_push), .call_frame(call_frame), .instr_ready(instr_ready),
        .working_register(working_register), .result_null_flag(result_null_flag),
        .rotate_bit_flag(rotate_bit_flag), .pc_out(pc_out), .pc_load(pc_load),
        .irq_return(irq_return), .data_reg_view(view));
    initial
    begin
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Issue one instruction; valid stays high after ALU ops for back-to-back issue
    task automatic issue(input orx_op_t op, input logic [3:0] a, input logic [7:0] l);
        instr_valid = 1'b1;
        instr = '{op, a, l};
        @(posedge clk_sys);
        #1;
        if (op inside {ORX_OP_SUB_EXIT, ORX_OP_LIT_EXIT, ORX_OP_IRQ_EXIT})
        begin
            instr_valid = 1'b0;
            check("ready_mid", instr_ready, 1'b0);
            check("pc_load_mid", pc_load, 1'b0);
            @(posedge clk_sys);
            #1;
            check("pc_load", pc_load, 1'b1);
        end
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            stop_test();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        check("rst_work", working_register, 8'h00);
        check("rst_ready", instr_ready, 1'b1);
        check("rst_pc_load", pc_load, 1'b0);
        foreach (rows[i])
        begin
            issue(rows[i].op, rows[i].addr, rows[i].lit);
            check("work", working_register, rows[i].work);
            check("zero", result_null_flag, rows[i].z);
            check("carry", rotate_bit_flag, rows[i].c);
            check("reg", view[rows[i].addr], rows[i].rv);
        end
        // Two nested entries, then unwind
        instr_valid = 1'b0;
        call_push = 1'b1;
        call_frame = '{11'h123, 1'b0};
        @(posedge clk_sys);
        #1;
        call_frame = '{11'h456, 1'b1};
        @(posedge clk_sys);
        #1;
        call_push = 1'b0;
        issue(ORX_OP_IRQ_EXIT, 4'h0, 8'h00);
        check("irq_exit_pc", pc_out, 11'h456);
        check("irq_exit_flag", irq_return, 1'b1);
        check("irq_exit_zero", result_null_flag, 1'b1);
        issue(ORX_OP_SUB_EXIT, 4'h0, 8'h00);
        check("sub_exit_pc", pc_out, 11'h123);
        check("sub_exit_irq", irq_return, 1'b0);
        check("sub_exit_zero", result_null_flag, 1'b1);
        check("sub_exit_work", working_register, 8'h00);
        // Reset in mid-run
        sys_rst = 1'b1;
        @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        check("rerst_reg", view[2], 8'h00);
        check("rerst_zero", result_null_flag, 1'b0);
        check("rerst_ready", instr_ready, 1'b1);
        issue(ORX_OP_ORI, 4'h0, 8'h55);
        check("post_work", working_register, 8'h55);
        check("post_zero", result_null_flag, 1'b0);
        stop_test();
    end
endmodule
